// ===== hdl/lhm_motion.sv
// Homing command executor: high-speed move to inner limit, constant-speed base seek
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module lhm_motion
    import lhm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Switch inputs, high when asserted
    input wire logic outer_limit_cw,
    input wire logic outer_limit_ccw,
    input wire logic inner_limit_cw,
    input wire logic inner_limit_ccw,
    input wire logic base_point_switch,
    input wire logic motor_power_fail,
    input wire logic ext_clk_in,
    // Motor drive
    output logic step_out,
    output logic dir_ccw_out,
    output logic busy_out
);
    lhm_state_e state_q; // Motion state
    logic [31:0] steps_q; // Signed step count staging
    logic [7:0] rate_q; // Step rate divisor staging
    logic [7:0] chan_q; // Channel select staging
    logic [1:0] src_q; // Clock source select
    logic init_a_q, init_b_q; // Channel initialized flags
    logic [7:0] prof_start_q, prof_top_q, prof_slope_q; // Stored profile
    logic [7:0] divider_q; // On-board divider ratio
    logic [7:0] run_rate_q; // Divisor loaded by the last started base seek
    logic [7:0] period_q; // Current step period
    logic [7:0] slope_cnt_q; // Steps between period changes
    logic dir_q; // 1 = counter-clockwise
    logic [3:0] result_q; // Last result code
    logic [7:0] finish_q; // Finish status byte
    logic fin_read_q; // One read of finish seen since done
    logic [2:0] last_cmd_q; // Low bits of last command
    logic [31:0] rdata_q; // Read data register
    logic step_q; // Registered step pulse
    logic busy_q; // Registered busy flag, one cycle behind the state
    logic tick, step_pulse;
    logic cmd_wr, go;
    logic [3:0] check_res;
    logic [7:0] cmd_code;
    logic inner_hit, outer_hit, base_hit;

    // Absolute value fits-in-range check for signed counts
    function automatic logic count_ok(input logic [31:0] v);
        logic [31:0] mag;
        mag = v[31] ? (~v + 32'h0000_0001) : v;
        count_ok = (mag <= COUNT_LIMIT);
    endfunction

    // Base tick source
    lhm_tick_gen u_tick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .src_sel(src_q),
        .divider_ratio(divider_q),
        .ext_clk_in(ext_clk_in),
        .tick(tick)
    );

    // Step timing
    lhm_step_timer u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(state_q != ST_IDLE),
        .tick(tick),
        .period(period_q),
        .step(step_pulse)
    );

    assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
    assign cmd_code = reg_wdata[7:0];

    // Direction-aware limit decode
    assign inner_hit = dir_q ? inner_limit_ccw : inner_limit_cw;
    assign outer_hit = dir_q ? outer_limit_ccw : outer_limit_cw;
    assign base_hit = base_point_switch;

    // Parameter checks in priority order
    always_comb begin
        if (state_q != ST_IDLE) begin
            check_res = RES_BUSY;
        end else if (cmd_code > CMD_MAX) begin
            check_res = RES_BAD_CMD;
        end else if (motor_power_fail) begin
            check_res = RES_HW_FAULT;
        end else if (chan_q > 8'h01) begin
            check_res = RES_BAD_CHAN;
        end else if (chan_q == 8'h00 && !init_a_q) begin
            check_res = RES_UNINIT_A;
        end else if (chan_q == 8'h01 && !init_b_q) begin
            check_res = RES_UNINIT_B;
        end else if (!count_ok(steps_q)) begin
            check_res = RES_BAD_COUNT;
        end else if (cmd_code == CMD_BASE_POINT && rate_q < RATE_MIN) begin
            check_res = RES_BAD_RATE;
        end else begin
            check_res = RES_OK;
        end
    end
    assign go = cmd_wr && (check_res == RES_OK)
        && (cmd_code == CMD_HIGH_SPEED || cmd_code == CMD_BASE_POINT);

    // Staging and configuration registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            steps_q <= 32'h0000_0000;
            rate_q <= RATE_MAX;
            chan_q <= 8'h00;
            src_q <= SRC_INTERNAL;
            init_a_q <= 1'b0;
            init_b_q <= 1'b0;
            divider_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == REG_STEPS) begin
                steps_q <= reg_wdata;
            end else if (reg_addr == REG_RATE) begin
                rate_q <= reg_wdata[7:0];
                chan_q <= reg_wdata[15:8];
            end else if (reg_addr == REG_CFG) begin
                src_q <= reg_wdata[1:0];
                init_a_q <= reg_wdata[4];
                init_b_q <= reg_wdata[5];
            end else if (reg_addr == REG_DIVIDER) begin
                divider_q <= reg_wdata[7:0];
            end
        end
    end

    // Stored profile only changes by its own register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prof_start_q <= PROF_START_RST;
            prof_top_q <= PROF_TOP_RST;
            prof_slope_q <= PROF_SLOPE_RST;
        end else if (reg_wr && reg_addr == REG_PROFILE) begin
            prof_start_q <= reg_wdata[7:0];
            prof_top_q <= reg_wdata[15:8];
            prof_slope_q <= reg_wdata[23:16];
        end
    end

    // Motion state machine
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            dir_q <= 1'b0;
            run_rate_q <= RATE_MAX;
            period_q <= RATE_MAX;
            slope_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        dir_q <= steps_q[31];
                        slope_cnt_q <= 8'h00;
                        if (cmd_code == CMD_HIGH_SPEED) begin
                            state_q <= ST_ACCEL;
                            period_q <= prof_start_q;
                        end else begin
                            state_q <= ST_CONST;
                            run_rate_q <= rate_q;
                            period_q <= rate_q;
                        end
                    end
                end
                ST_ACCEL: begin
                    if (outer_hit) begin
                        state_q <= ST_IDLE;
                    end else if (inner_hit) begin
                        state_q <= ST_DECEL;
                        slope_cnt_q <= 8'h00;
                    end else if (step_pulse) begin
                        if (slope_cnt_q + 8'h01 >= prof_slope_q) begin
                            slope_cnt_q <= 8'h00;
                            if (period_q > prof_top_q) begin
                                period_q <= period_q - 8'h01;
                            end
                        end else begin
                            slope_cnt_q <= slope_cnt_q + 8'h01;
                        end
                    end
                end
                ST_DECEL: begin
                    if (outer_hit || period_q >= prof_start_q) begin
                        state_q <= ST_IDLE;
                    end else if (step_pulse) begin
                        if (slope_cnt_q + 8'h01 >= prof_slope_q) begin
                            slope_cnt_q <= 8'h00;
                            period_q <= period_q + 8'h01;
                        end else begin
                            slope_cnt_q <= slope_cnt_q + 8'h01;
                        end
                    end
                end
                ST_CONST: begin
                    if (base_hit || outer_hit) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Result code of each command write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_q <= RES_OK;
        end else if (cmd_wr) begin
            result_q <= check_res;
        end
    end

    // Finish status: stop cause bits and done flag
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            finish_q <= 8'h00;
            fin_read_q <= 1'b0;
            last_cmd_q <= 3'h0;
        end else if (go) begin
            finish_q <= 8'h00;
            fin_read_q <= 1'b0;
            last_cmd_q <= cmd_code[2:0];
        end else if ((state_q == ST_ACCEL || state_q == ST_DECEL) && outer_hit) begin
            finish_q[FIN_OUTER_BIT] <= 1'b1;
            finish_q[FIN_DONE_BIT] <= 1'b1;
        end else if (state_q == ST_DECEL && period_q >= prof_start_q) begin
            finish_q[FIN_INNER_BIT] <= 1'b1;
            finish_q[FIN_DONE_BIT] <= 1'b1;
        end else if (state_q == ST_CONST && (base_hit || outer_hit)) begin
            finish_q[FIN_BASE_BIT] <= base_hit;
            finish_q[FIN_OUTER_BIT] <= !base_hit;
            finish_q[FIN_DONE_BIT] <= 1'b1;
        end else if (reg_rd && reg_addr == REG_FINISH && finish_q[FIN_DONE_BIT]) begin
            if (fin_read_q) begin
                finish_q[FIN_DONE_BIT] <= 1'b0;
            end
            fin_read_q <= !fin_read_q;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == REG_STEPS) begin
                rdata_q <= steps_q;
            end else if (reg_addr == REG_RATE) begin
                rdata_q <= {16'h0000, chan_q, rate_q};
            end else if (reg_addr == REG_CFG) begin
                rdata_q <= {26'h0, init_b_q, init_a_q, 2'h0, src_q};
            end else if (reg_addr == REG_RESULT) begin
                rdata_q <= {27'h0, state_q != ST_IDLE, result_q};
            end else if (reg_addr == REG_FINISH) begin
                rdata_q <= {24'h0, finish_q[7:3], last_cmd_q};
            end else if (reg_addr == REG_PROFILE) begin
                rdata_q <= {8'h00, prof_slope_q, prof_top_q, prof_start_q};
            end else if (reg_addr == REG_DIVIDER) begin
                rdata_q <= {24'h0, divider_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // Registered motor outputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            step_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            step_q <= step_pulse;
            busy_q <= (state_q != ST_IDLE);
        end
    end

    assign reg_rdata = rdata_q;
    assign step_out = step_q;
    assign dir_ccw_out = dir_q;
    assign busy_out = busy_q;

    // Busy command gets code 1 next cycle
    a_busy_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_wr && state_q != ST_IDLE) |=> (result_q == RES_BUSY
        && (state_q == $past(state_q) || state_q == ST_IDLE || state_q == ST_DECEL)))
        else $error("busy command not refused");
    // Bad rate on base command gives 11
    a_rate_range: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_wr && state_q == ST_IDLE && cmd_code == CMD_BASE_POINT && check_res == RES_BAD_RATE)
        |=> (result_q == 4'hb && state_q == ST_IDLE))
        else $error("bad divisor accepted");
    // Bad channel gives 10
    a_chan_check: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_wr && state_q == ST_IDLE && cmd_code <= CMD_MAX && !motor_power_fail && chan_q > 8'h01)
        |=> result_q == 4'ha)
        else $error("bad channel not reported");
    // Inner limit leads to deceleration
    a_inner_decel: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_ACCEL && !outer_hit && inner_hit) |=> state_q == ST_DECEL)
        else $error("no decel on inner limit");
    // Base seek stops on switch, records cause
    a_base_stop: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_CONST && base_hit) |=> (state_q == ST_IDLE && finish_q[5] && finish_q[7]))
        else $error("base point stop wrong");
    // Outer limit stop in base seek sets bit 4
    a_outer_stop: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_CONST && !base_hit && outer_hit) |=> (state_q == ST_IDLE && finish_q[4]))
        else $error("outer stop wrong");
    // Direction follows count sign
    a_dir_sign: assert property (@(posedge mclk) disable iff (sys_rst)
        go |=> dir_ccw_out == $past(steps_q[31]))
        else $error("direction not from sign");
    // Profile start and top untouched by a started command
    a_prof_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        (go && !(reg_wr && reg_addr == REG_PROFILE)) |=> $stable(prof_top_q) && $stable(prof_start_q))
        else $error("profile overwritten");
endmodule
`default_nettype wire

// ===== hdl/lhm_pkg.sv
// Package of constants and types for the limit and home motion block
`default_nettype none
package lhm_pkg;
    // Command codes
    localparam logic [7:0] CMD_HIGH_SPEED = 8'h06;
    localparam logic [7:0] CMD_BASE_POINT = 8'h07;
    localparam logic [7:0] CMD_MAX = 8'h0c;
    // Result codes
    localparam logic [3:0] RES_OK = 4'h0;
    localparam logic [3:0] RES_BUSY = 4'h1;
    localparam logic [3:0] RES_UNINIT_A = 4'h2;
    localparam logic [3:0] RES_UNINIT_B = 4'h3;
    localparam logic [3:0] RES_BAD_CMD = 4'h4;
    localparam logic [3:0] RES_HW_FAULT = 4'h5;
    localparam logic [3:0] RES_BAD_COUNT = 4'h6;
    localparam logic [3:0] RES_BAD_CHAN = 4'ha;
    localparam logic [3:0] RES_BAD_RATE = 4'hb;
    // Parameter ranges
    localparam logic [7:0] RATE_MIN = 8'h14;
    localparam logic [7:0] RATE_MAX = 8'hff;
    localparam logic [31:0] COUNT_LIMIT = 32'h00ff_ffff;
    // Clock sources
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_ONBOARD = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    // Base tick rates in Hz and their periods in mclk cycles
    localparam int CLK_HZ = 100_000_000;
    localparam int INT_TICK_HZ = 12_500;
    localparam int ONB_TICK_HZ = 100_000;
    localparam int INT_TICK_CYC = CLK_HZ / INT_TICK_HZ;
    localparam int ONB_TICK_CYC = CLK_HZ / ONB_TICK_HZ;
    // Register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STEPS = 4'h1;
    localparam logic [3:0] REG_RATE = 4'h2;
    localparam logic [3:0] REG_CFG = 4'h3;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_FINISH = 4'h5;
    localparam logic [3:0] REG_PROFILE = 4'h6;
    localparam logic [3:0] REG_DIVIDER = 4'h7;
    // Finish status bit positions
    localparam int FIN_INNER_BIT = 3;
    localparam int FIN_OUTER_BIT = 4;
    localparam int FIN_BASE_BIT = 5;
    localparam int FIN_DONE_BIT = 7;
    // Profile reset values
    localparam logic [7:0] PROF_START_RST = 8'hc8;
    localparam logic [7:0] PROF_TOP_RST = 8'h14;
    localparam logic [7:0] PROF_SLOPE_RST = 8'h04;
    // Motion states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCEL = 2'b01,
        ST_DECEL = 2'b10,
        ST_CONST = 2'b11
    } lhm_state_e;
endpackage
`default_nettype wire

// ===== hdl/lhm_tick_gen.sv
// Base tick generator selecting internal, on-board or external rate source
`default_nettype none
module lhm_tick_gen
    import lhm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Source selection
    input wire logic [1:0] src_sel,
    input wire logic [7:0] divider_ratio,
    input wire logic ext_clk_in,
    // Base tick out
    output logic tick
);
    logic [15:0] pre_q; // Prescale count
    logic [7:0] div_q; // On-board divider count
    logic ext_s1_q, ext_s2_q, ext_s3_q; // External edge detect
    logic onb_tick; // Prescaler tick: 100 kHz, or 12.5 kHz with the internal source

    // Prescaler toward the internal or on-board base rate
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_q <= 16'h0000;
        end else if (src_sel == SRC_INTERNAL) begin
            pre_q <= (pre_q >= 16'(INT_TICK_CYC - 1)) ? 16'h0000 : pre_q + 16'h0001;
        end else begin
            pre_q <= (pre_q >= 16'(ONB_TICK_CYC - 1)) ? 16'h0000 : pre_q + 16'h0001;
        end
    end
    assign onb_tick = (pre_q == 16'h0000);

    // On-board divider: compares to live ratio so rewrites act at once
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_q <= 8'h00;
        end else if (onb_tick) begin
            div_q <= (div_q >= divider_ratio) ? 8'h00 : div_q + 8'h01;
        end
    end

    // External clock rising edge detection
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Select tick per source
    always_comb begin
        case (src_sel)
            SRC_INTERNAL: tick = onb_tick;
            SRC_ONBOARD: tick = onb_tick && (div_q == 8'h00);
            SRC_EXTERNAL: tick = ext_s2_q && !ext_s3_q;
            default: tick = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/lhm_step_timer.sv
// Step interval timer: one step pulse every period base ticks
`default_nettype none
module lhm_step_timer
    import lhm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic tick,
    input wire logic [7:0] period,
    // Step pulse
    output logic step
);
    logic [7:0] cnt_q; // Ticks since last step

    // Count base ticks, step when period reached
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            cnt_q <= 8'h00;
        end else if (tick) begin
            cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
        end
    end
    assign step = run && tick && (cnt_q + 8'h01 >= period);
endmodule
`default_nettype wire

// ===== verif/lhm_motor_model.sv
// Behavioural motor stage whose shaft position closes the switches
`default_nettype none
module lhm_motor_model #(
    parameter int BP_POS = 3,
    parameter int OCW_POS = 40,
    parameter int OCCW_POS = -2,
    parameter int ICW_POS = 6,
    parameter int ICCW_POS = -20
) (
    // Drive side
    input wire logic mclk,
    input wire logic step_out,
    input wire logic dir_ccw_out,
    // Switch side
    output logic outer_limit_cw,
    output logic outer_limit_ccw,
    output logic inner_limit_cw,
    output logic inner_limit_ccw,
    output logic base_point_switch,
    output var int pos
);
    timeunit 1ns;
    timeprecision 1ns;
    int pos_q = 0; // Shaft position in steps
    // Shaft moves one place per step pulse
    always @(posedge mclk) begin
        if (step_out === 1'b1) begin
            pos_q <= (dir_ccw_out === 1'b1) ? pos_q - 1 : pos_q + 1;
        end
    end
    assign pos = pos_q;
    // Limits stay closed at and beyond their place
    assign outer_limit_cw = pos_q >= OCW_POS;
    assign outer_limit_ccw = pos_q <= OCCW_POS;
    assign inner_limit_cw = pos_q >= ICW_POS;
    assign inner_limit_ccw = pos_q <= ICCW_POS;
    // Base point is a narrow cam
    assign base_point_switch = pos_q == BP_POS;
endmodule
`default_nettype wire

// ===== verif/test_limit_and_home_motion_cmds.sv
// Self-checking bench for the homing command executor
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module test_limit_and_home_motion_cmds
    import lhm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Bench drive
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_fail = 1'b0;
    logic ext_clk = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_q;
    // Switches and motor side
    logic ocw, occw, icw, iccw, bps, step, dir, busy;
    int pos;
    int cyc = 0;
    int t0;
    int err_total = 0;
    int comparisons = 0;
    // Clock and external step clock of 4 cycles
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc[0]) begin
            ext_clk <= ~ext_clk;
        end
        // Ceiling above two slow on-board step gaps plus the short moves
        if (cyc == 95000) begin
            err_total++;
            print_verdict();
        end
    end
    lhm_motion uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .outer_limit_cw(ocw),
        .outer_limit_ccw(occw), .inner_limit_cw(icw), .inner_limit_ccw(iccw), .base_point_switch(bps),
        .motor_power_fail(power_fail), .ext_clk_in(ext_clk), .step_out(step), .dir_ccw_out(dir),
        .busy_out(busy));
    lhm_motor_model motor (.mclk(mclk), .step_out(step), .dir_ccw_out(dir), .outer_limit_cw(ocw),
        .outer_limit_ccw(occw), .inner_limit_cw(icw), .inner_limit_ccw(iccw), .base_point_switch(bps),
        .pos(pos));
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_q = reg_rdata;
    endtask
    // Load parameters, issue a command, check its result
    task automatic cmd(input logic [7:0] c, input logic [31:0] s, input logic [15:0] rc, input logic [3:0] e);
        wr(REG_STEPS, s);
        wr(REG_RATE, {16'h0, rc});
        wr(REG_CMD, {24'h0, c});
        rd(REG_RESULT);
        `CHK("result", e, rd_q[3:0])
    endtask
    // Bounded wait for the move to end
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 60000) begin
            @(posedge mclk);
            n++;
        end
        `CHK("idle", 1'b0, busy)
    endtask
    // Cycles between two step pulses
    task automatic gap(output int g);
        @(posedge mclk iff step === 1'b1);
        t0 = cyc;
        @(posedge mclk iff step === 1'b1);
        g = cyc - t0;
    endtask
    // Closing report
    task automatic print_verdict;
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        int g;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        // Short profile: start 30, top 20, slope 1
        wr(REG_PROFILE, 32'h0001_141e);
        wr(REG_CFG, 32'h02);
        cmd(CMD_BASE_POINT, 32'h1, 16'h0014, RES_UNINIT_A);
        wr(REG_CFG, 32'h12);
        cmd(CMD_BASE_POINT, 32'h1, 16'h0114, RES_UNINIT_B);
        wr(REG_CFG, 32'h32);
        // Parameter refusals and boundaries
        cmd(8'h0d, 32'h1, 16'h0014, RES_BAD_CMD);
        cmd(CMD_BASE_POINT, 32'h1, 16'h0214, RES_BAD_CHAN);
        cmd(CMD_BASE_POINT, 32'h0100_0000, 16'h0014, RES_BAD_COUNT);
        cmd(CMD_BASE_POINT, 32'hff00_0000, 16'h0014, RES_BAD_COUNT);
        cmd(8'h04, 32'h00ff_ffff, 16'h0014, RES_OK);
        cmd(CMD_BASE_POINT, 32'h1, 16'h0013, RES_BAD_RATE);
        power_fail <= 1'b1;
        cmd(CMD_BASE_POINT, 32'h1, 16'h0014, RES_HW_FAULT);
        power_fail <= 1'b0;
        // Seek ccw, base point not on the way: stop on outer limit
        cmd(CMD_BASE_POINT, 32'hffff_ffff, 16'h0014, RES_OK);
        wait_idle();
        `CHK("dir ccw", 1'b1, dir)
        `CHK("pos ccw", -2, pos)
        rd(REG_FINISH);
        `CHK("fin outer", 8'h97, rd_q[7:0])
        // Seek cw to base point, second command refused meanwhile
        cmd(CMD_BASE_POINT, 32'h0000_0005, 16'h0014, RES_OK);
        cmd(CMD_HIGH_SPEED, 32'h0000_0005, 16'h0014, RES_BUSY);
        gap(g);
        `CHK("ext gap", 80, g)
        `CHK("busy", 1'b1, busy)
        wait_idle();
        `CHK("dir cw", 1'b0, dir)
        `CHK("pos base", 3, pos)
        rd(REG_FINISH);
        `CHK("fin base", 8'ha7, rd_q[7:0])
        rd(REG_FINISH);
        rd(REG_FINISH);
        `CHK("done clear", 1'b0, rd_q[FIN_DONE_BIT])
        rd(REG_PROFILE);
        `CHK("profile", 24'h01_141e, rd_q[23:0])
        // High-speed move: rate field ignored, decelerates past inner limit
        cmd(CMD_HIGH_SPEED, 32'h0000_0009, 16'h0000, RES_OK);
        wait_idle();
        `CHK("past inner", 1'b1, pos >= 6 && pos < 40)
        rd(REG_FINISH);
        `CHK("fin inner", 8'h8e, rd_q[7:0])
        // On-board source with ratio 1: 20 x 2 x 1000 cycles a step
        wr(REG_CFG, 32'h31);
        wr(REG_DIVIDER, 32'h1);
        cmd(CMD_BASE_POINT, 32'hffff_fff0, 16'h0014, RES_OK);
        gap(g);
        `CHK("onboard gap", 40000, g)
        print_verdict();
    end
endmodule
`default_nettype wire
